//--- src/bps_pkg.sv
package bps_pkg;
	// bus address and register offsets
	localparam logic [6:0] SLAVE_ADDR = 7'h60;
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_P_HI = 8'h01;
	localparam logic [7:0] A_P_MID = 8'h02;
	localparam logic [7:0] A_P_LO = 8'h03;
	localparam logic [7:0] A_T_HI = 8'h04;
	localparam logic [7:0] A_T_LO = 8'h05;
	localparam logic [7:0] A_DRS = 8'h06;
	localparam logic [7:0] A_DP_HI = 8'h07;
	localparam logic [7:0] A_DP_MID = 8'h08;
	localparam logic [7:0] A_DP_LO = 8'h09;
	localparam logic [7:0] A_DT_HI = 8'h0a;
	localparam logic [7:0] A_DT_LO = 8'h0b;
	localparam logic [7:0] A_PART_ID = 8'h0c;
	localparam logic [7:0] A_BUF_STAT = 8'h0d;
	localparam logic [7:0] A_BUF_DATA = 8'h0e;
	localparam logic [7:0] A_BUF_SETUP = 8'h0f;
	localparam logic [7:0] A_TDLY = 8'h10;
	localparam logic [7:0] A_SYSMODE = 8'h11;
	localparam logic [7:0] A_ICAUSE = 8'h12;
	localparam logic [7:0] A_EVCFG = 8'h13;
	localparam logic [7:0] A_REF_HI = 8'h14;
	localparam logic [7:0] A_REF_LO = 8'h15;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_REF_HI = 8'hc5;
	localparam logic [7:0] RST_REF_LO = 8'he7;
	// field positions
	localparam int DRS_RDY = 3;
	localparam int DRS_OW = 7;
	localparam int IC_PCHG = 0;
	localparam int IC_TCHG = 1;
	localparam int IC_TW = 3;
	localparam int IC_FIFO = 6;
	localparam int IC_DRDY = 7;
	localparam int BUF_MODE_HI = 7;
	localparam int BUF_MODE_LO = 6;
	localparam int SYSMODE_ACT = 0;
	// sample and byte widths
	localparam int P_W = 20;
	localparam int T_W = 12;
	localparam int BYTE_BITS = 8;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
	} bps_state_t;
endpackage

//--- src/bps_regs.sv
// How it works
// - temperature window flag never sets while the window value is zero.
// - pressure change flag sets when consecutive pressure samples differ beyond window.
// - temperature change flag uses the pressure window value as threshold.
// - data-ready flag follows the ready or overwrite status bits.
// - buffer flag sets on buffer overflow or watermark.
// - each sample after the first updates pressure and temperature deltas against the previous; the first zeroes them.
// - running minimum and maximum of pressure and temperature kept.
// - falling data with clock high starts a transaction; bus busy.
// - first byte carries seven-bit address and direction; respond only on match.
// - ninth clock is acknowledge; receiver holds data low through high phase.
// - any byte count; master may stretch clock low, logic just waits.
// - rising data with clock high is stop and ends the transfer.
// - slave answers at seven-bit address 0x60 (0xC0 write, 0xC1 read).
// - pressure bytes at 0x01-0x03 high first; temperature at 0x04-0x05.
// - burst pointer wraps from 0x05 back to 0x00.
// - delta bytes at 0x07-0x0B; burst pointer wraps from 0x0B to 0x06.
// - buffer data port keeps the pointer still on successive reads.
// - address 0x00 returns ready status or buffer status by buffer use.
// - sea-level reference bytes reset to 0xC5, 0xE7 and are writable.
// - read-only identification byte, untouched by mode transitions.
// - works at 100 kHz and 400 kHz; both lines idle high.
// - buffer mode non-zero aliases 0x00 to buffer status, 0x01 to data.
// - standby-to-active clears output, status, delta, delay and mode registers.
module bps_regs #(
	parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_pin_out,
	output logic sda_pin_oe_n,
	input wire logic sample_valid,
	input wire logic [bps_pkg::P_W-1:0] sample_pressure,
	input wire logic [bps_pkg::T_W-1:0] sample_temp,
	input wire logic [15:0] pressure_window,
	input wire logic [7:0] temp_target,
	input wire logic [7:0] temp_window_value,
	input wire logic go_active,
	input wire logic active_mode,
	input wire logic [7:0] buffer_flags,
	input wire logic [7:0] buffer_byte,
	input wire logic buffer_overflow,
	input wire logic buffer_watermark,
	output logic buffer_pop,
	output logic [1:0] buffer_mode,
	output logic [15:0] sea_level_ref,
	output logic [7:0] event_config,
	output logic [7:0] int_flags,
	output logic [bps_pkg::P_W-1:0] pressure_min,
	output logic [bps_pkg::P_W-1:0] pressure_max,
	output logic [bps_pkg::T_W-1:0] temp_min,
	output logic [bps_pkg::T_W-1:0] temp_max
);
	import bps_pkg::*;

	function automatic logic [7:0] next_addr(input logic [7:0] a, input logic buf_on);
		logic [7:0] n;
		n = a + 8'h01;
		if (a == A_T_LO)
			n = A_STATUS;
		if (a == A_DT_LO)
			n = A_DRS;
		if (a == A_BUF_DATA || (buf_on && a == A_P_HI))
			n = a;
		return n;
	endfunction

	// pin synchronisers; stage 1 feeds stage 2 only
	logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'b111;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'b111;
		end
		else
		begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_pin, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_pin_in, sda_s1_q, sda_s2_q};
		end
	end

	wire scl_rise = scl_s2_q & ~scl_s3_q;
	wire scl_fall = ~scl_s2_q & scl_s3_q;
	wire bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
	wire bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

	bps_state_t st_q;
	logic [7:0] shift_q, ptr_q;
	logic [3:0] bit_q;
	logic rw_q, ptr_set_q, drive_q;

	logic [7:0] setup_q, evcfg_q, ref_hi_q, ref_lo_q, drs_q, tdly_q, sysmode_q, icause_q;
	logic [P_W-1:0] out_p_q, dp_q;
	logic [T_W-1:0] out_t_q, dt_q;

	wire buf_on = setup_q[BUF_MODE_HI:BUF_MODE_LO] != 2'b00;
	wire byte_done = bit_q == 4'd8;
	wire addr_hit = shift_q[7:1] == SLAVE_ADDR;
	wire load_rd = scl_fall & ((st_q == ST_AACK & rw_q) | st_q == ST_RACK);
	wire wr_en = scl_fall & st_q == ST_WR & byte_done & ptr_set_q;
	wire ptr_wr = scl_fall & st_q == ST_WR & byte_done & ~ptr_set_q;
	wire [7:0] ptr_next = next_addr(ptr_q, buf_on);

	wire [7:0] p_hi = out_p_q[19:12];
	wire [7:0] p_mid = out_p_q[11:4];
	wire [7:0] p_lo = {out_p_q[3:0], 4'h0};
	wire [7:0] t_hi = out_t_q[11:4];
	wire [7:0] t_lo = {out_t_q[3:0], 4'h0};

	logic [7:0] rd_byte;
	always_comb
	begin
		unique case (ptr_q)
			A_STATUS: rd_byte = buf_on ? buffer_flags : drs_q;
			A_P_HI: rd_byte = buf_on ? buffer_byte : p_hi;
			A_P_MID: rd_byte = p_mid;
			A_P_LO: rd_byte = p_lo;
			A_T_HI: rd_byte = t_hi;
			A_T_LO: rd_byte = t_lo;
			A_DRS: rd_byte = drs_q;
			A_DP_HI: rd_byte = dp_q[19:12];
			A_DP_MID: rd_byte = dp_q[11:4];
			A_DP_LO: rd_byte = {dp_q[3:0], 4'h0};
			A_DT_HI: rd_byte = dt_q[11:4];
			A_DT_LO: rd_byte = {dt_q[3:0], 4'h0};
			A_PART_ID: rd_byte = PART_ID;
			A_BUF_STAT: rd_byte = buffer_flags;
			A_BUF_DATA: rd_byte = buffer_byte;
			A_BUF_SETUP: rd_byte = setup_q;
			A_TDLY: rd_byte = tdly_q;
			A_SYSMODE: rd_byte = sysmode_q;
			A_ICAUSE: rd_byte = icause_q;
			A_EVCFG: rd_byte = evcfg_q;
			A_REF_HI: rd_byte = ref_hi_q;
			A_REF_LO: rd_byte = ref_lo_q;
			default: rd_byte = RST_ZERO;
		endcase
	end

	// slave engine; clock stretching needs nothing, edges just arrive late
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_q <= 4'd0;
			rw_q <= 1'b0;
			ptr_set_q <= 1'b0;
			drive_q <= 1'b0;
		end
		else if (bus_start)
		begin
			st_q <= ST_ADDR;
			bit_q <= 4'd0;
			drive_q <= 1'b0;
		end
		else if (bus_stop)
		begin
			st_q <= ST_IDLE;
			drive_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE:
				begin
					drive_q <= 1'b0;
				end
				ST_ADDR, ST_WR:
				begin
					if (scl_rise && !byte_done)
					begin
						shift_q <= {shift_q[6:0], sda_s2_q};
						bit_q <= bit_q + 4'd1;
					end
					else if (scl_fall && byte_done)
					begin
						drive_q <= st_q == ST_WR || addr_hit;
						if (st_q == ST_WR)
							st_q <= ST_WACK;
						else
							st_q <= addr_hit ? ST_AACK : ST_IDLE;
						if (st_q == ST_ADDR)
							rw_q <= shift_q[0];
						if (st_q == ST_WR)
							ptr_set_q <= 1'b1;
					end
				end
				ST_AACK, ST_RACK:
				begin
					if (scl_rise && st_q == ST_RACK && sda_s2_q)
					begin
						// master nack ends the burst
						st_q <= ST_IDLE;
					end
					else if (scl_fall)
					begin
						bit_q <= rw_q ? 4'd1 : 4'd0;
						st_q <= rw_q ? ST_RD : ST_WR;
						shift_q <= rd_byte;
						drive_q <= rw_q & ~rd_byte[7];
						if (!rw_q)
							ptr_set_q <= 1'b0;
					end
				end
				ST_WACK:
				begin
					if (scl_fall)
					begin
						st_q <= ST_WR;
						bit_q <= 4'd0;
						drive_q <= 1'b0;
					end
				end
				ST_RD:
				begin
					if (scl_fall)
					begin
						// transmitter releases for the ack clock
						if (byte_done)
						begin
							st_q <= ST_RACK;
							drive_q <= 1'b0;
						end
						else
						begin
							shift_q <= {shift_q[6:0], 1'b0};
							drive_q <= ~shift_q[6];
							bit_q <= bit_q + 4'd1;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// open drain: only ever pulls low
	assign sda_pin_out = 1'b0;
	assign sda_pin_oe_n = ~drive_q;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ptr_q <= 8'h00;
		else if (ptr_wr)
			ptr_q <= shift_q;
		else if (wr_en || load_rd)
			ptr_q <= ptr_next;
	end

	// configuration survives mode changes; only reset or a bus write touches it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			setup_q <= RST_ZERO;
			evcfg_q <= RST_ZERO;
			ref_hi_q <= RST_REF_HI;
			ref_lo_q <= RST_REF_LO;
		end
		else if (wr_en)
		begin
			if (ptr_q == A_BUF_SETUP)
				setup_q <= shift_q;
			if (ptr_q == A_EVCFG)
				evcfg_q <= shift_q;
			if (ptr_q == A_REF_HI)
				ref_hi_q <= shift_q;
			if (ptr_q == A_REF_LO)
				ref_lo_q <= shift_q;
		end
	end

	wire [P_W-1:0] dp_new = sample_pressure - out_p_q;
	wire [T_W-1:0] dt_new = sample_temp - out_t_q;
	wire [P_W-1:0] dp_abs = dp_new[P_W-1] ? P_W'(-dp_new) : dp_new;
	wire [T_W-1:0] dt_abs = dt_new[T_W-1] ? T_W'(-dt_new) : dt_new;
	logic have_q;
	wire set_pchg = sample_valid & have_q & (dp_abs > {4'h0, pressure_window});
	wire set_tchg = sample_valid & have_q & ({4'h0, dt_abs} > pressure_window);
	wire [8:0] tw_diff = {sample_temp[11], sample_temp[11:4]} - {temp_target[7], temp_target};
	wire [8:0] tw_abs = tw_diff[8] ? 9'(-tw_diff) : tw_diff;
	wire set_tw = sample_valid & (temp_window_value != 8'h00) & (tw_abs <= {1'b0, temp_window_value});
	wire set_drdy = drs_q[DRS_RDY] | drs_q[DRS_OW];
	wire set_fifo = buffer_overflow | buffer_watermark;
	wire [7:0] ic_set = (8'(set_pchg) << IC_PCHG) | (8'(set_tchg) << IC_TCHG)
		| (8'(set_tw) << IC_TW) | (8'(set_fifo) << IC_FIFO) | (8'(set_drdy) << IC_DRDY);
	wire ic_clr = load_rd & ptr_q == A_ICAUSE;
	wire drs_clr = load_rd & ptr_q == A_T_LO;
	wire [7:0] drs_set = (8'(sample_valid) << DRS_RDY)
		| (8'(sample_valid & drs_q[DRS_RDY]) << DRS_OW);

	// set wins over a read-clear in the same cycle
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			icause_q <= RST_ZERO;
		else
			icause_q <= ic_set | (ic_clr ? RST_ZERO : icause_q);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_p_q <= '0;
			out_t_q <= '0;
			dp_q <= '0;
			dt_q <= '0;
			drs_q <= RST_ZERO;
			tdly_q <= RST_ZERO;
			sysmode_q <= RST_ZERO;
			have_q <= 1'b0;
		end
		else if (go_active)
		begin
			out_p_q <= '0;
			out_t_q <= '0;
			dp_q <= '0;
			dt_q <= '0;
			drs_q <= RST_ZERO;
			tdly_q <= RST_ZERO;
			sysmode_q <= RST_ZERO;
			have_q <= 1'b0;
		end
		else
		begin
			sysmode_q <= 8'(active_mode) << SYSMODE_ACT;
			drs_q <= drs_set | (drs_clr ? RST_ZERO : drs_q);
			if (sample_valid)
			begin
				out_p_q <= sample_pressure;
				out_t_q <= sample_temp;
				dp_q <= have_q ? dp_new : '0;
				dt_q <= have_q ? dt_new : '0;
				have_q <= 1'b1;
				if (buffer_overflow && tdly_q != 8'hff)
					tdly_q <= tdly_q + 8'h01;
			end
		end
	end

	// running extremes, seeded by the first sample
	logic mm_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mm_q <= 1'b0;
			pressure_min <= '0;
			pressure_max <= '0;
			temp_min <= '0;
			temp_max <= '0;
		end
		else if (sample_valid)
		begin
			mm_q <= 1'b1;
			if (!mm_q || sample_pressure < pressure_min)
				pressure_min <= sample_pressure;
			if (!mm_q || sample_pressure > pressure_max)
				pressure_max <= sample_pressure;
			if (!mm_q || sample_temp < temp_min)
				temp_min <= sample_temp;
			if (!mm_q || sample_temp > temp_max)
				temp_max <= sample_temp;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			buffer_pop <= 1'b0;
		else
			buffer_pop <= load_rd & (ptr_q == A_BUF_DATA | (buf_on & ptr_q == A_P_HI));
	end

	assign buffer_mode = setup_q[BUF_MODE_HI:BUF_MODE_LO];
	assign sea_level_ref = {ref_hi_q, ref_lo_q};
	assign event_config = evcfg_q;
	assign int_flags = icause_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_tw_zero: assert property (temp_window_value == 8'h00 |-> !set_tw)
		else $error("window flag raised with zero window");
	chk_pchg_set: assert property (set_pchg && !ic_clr |=> icause_q[IC_PCHG])
		else $error("pressure change flag missed");
	chk_delta_upd: assert property (sample_valid && have_q && !go_active
		|=> dp_q == $past(dp_new) && dt_q == $past(dt_new))
		else $error("delta registers not updated");
	chk_addr_ack: assert property (st_q == ST_ADDR && scl_fall && byte_done && addr_hit
		|=> !sda_pin_oe_n && st_q == ST_AACK)
		else $error("address ack not driven");
	chk_addr_miss: assert property (st_q == ST_ADDR && scl_fall && byte_done && !addr_hit
		&& !bus_start && !bus_stop |=> sda_pin_oe_n[*2])
		else $error("responded to foreign address");
	chk_wrap_temp: assert property (load_rd && ptr_q == A_T_LO |=> ptr_q == A_STATUS)
		else $error("pointer did not wrap to status");
	chk_wrap_delta: assert property (load_rd && ptr_q == A_DT_LO |=> ptr_q == A_DRS)
		else $error("pointer did not wrap to delta status");
	chk_port_hold: assert property (load_rd && ptr_q == A_BUF_DATA
		|=> ptr_q == A_BUF_DATA && buffer_pop)
		else $error("buffer port moved pointer");
	chk_act_clear: assert property (go_active |=> drs_q == RST_ZERO && dp_q == '0
		&& tdly_q == RST_ZERO)
		else $error("activation did not clear state");
	chk_stop_idle: assert property (bus_stop |=> st_q == ST_IDLE && sda_pin_oe_n)
		else $error("stop did not release bus");
	chk_ptr_load: assert property (ptr_wr && !bus_start && !bus_stop
		|=> ptr_q == $past(shift_q))
		else $error("pointer byte not loaded");

	cov_read_burst: cover property (st_q == ST_RACK ##[1:1000] st_q == ST_RD);
	cov_rep_start: cover property (st_q == ST_WR ##[1:1000] bus_start);
	cov_ref_write: cover property (wr_en && ptr_q == A_REF_HI);
	cov_fifo_alias: cover property (buf_on && load_rd && ptr_q == A_P_HI);
endmodule

//--- testbench/bps_host.sv
module bps_host (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic slow;
	logic [7:0] naks;
	logic [7:0] rb [0:7];
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
		slow = 1'b0;
		naks = 8'h00;
	end
	// quarter of a 400 ns link period
	task automatic q();
		repeat (2) @(negedge clk);
	endtask
	task automatic start();
		q();
		q();
		sda_drv = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b0;
		q();
		scl = 1'b0;
	endtask
	task automatic stop();
		q();
		q();
		sda_drv = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b1;
		q();
	endtask
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_drv = b;
		q();
		scl = 1'b1;
		q();
		q();
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ack_out, output logic [7:0] r,
		output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ack_out, ack_in);
		if (slow)
			repeat (12) q();
	endtask
	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic k;
		byte_io(b, 1'b1, r, k);
		naks = naks + {7'h00, k};
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
		start();
		send(8'hc0);
		send(a);
		for (int i = 0; i < n; i++)
			send(d[15 - 8 * i -: 8]);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		logic k;
		start();
		send(8'hc0);
		send(a);
		start();
		send(8'hc1);
		for (int i = 0; i < n; i++)
			byte_io(8'hff, (i == n - 1), rb[i], k);
		stop();
	endtask
	task automatic probe(input logic [7:0] b);
		start();
		send(b);
		stop();
	endtask
endmodule

//--- testbench/bps_regs_tb.sv
module bps_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bps_pkg::*;
	logic clk, sys_rst, scl, sda_drv, sda_line, sda_pin_out, sda_pin_oe_n;
	logic sample_valid, go_active, active_mode, buffer_overflow, buffer_watermark;
	logic buffer_pop;
	logic [19:0] sample_pressure, pressure_min, pressure_max;
	logic [11:0] sample_temp, temp_min, temp_max;
	logic [15:0] pressure_window, sea_level_ref;
	logic [7:0] temp_target, temp_window_value, buffer_flags, buffer_byte;
	logic [7:0] event_config, int_flags;
	logic [1:0] buffer_mode;
	int miscompares, checks, pops;
	// open drain with pull-up
	assign sda_line = sda_drv & (sda_pin_oe_n | sda_pin_out);
	bps_regs u_dut (.clk(clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_pin_in(sda_line),
		.sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n), .sample_valid(sample_valid),
		.sample_pressure(sample_pressure), .sample_temp(sample_temp),
		.pressure_window(pressure_window), .temp_target(temp_target),
		.temp_window_value(temp_window_value), .go_active(go_active),
		.active_mode(active_mode), .buffer_flags(buffer_flags), .buffer_byte(buffer_byte),
		.buffer_overflow(buffer_overflow), .buffer_watermark(buffer_watermark),
		.buffer_pop(buffer_pop), .buffer_mode(buffer_mode), .sea_level_ref(sea_level_ref),
		.event_config(event_config), .int_flags(int_flags), .pressure_min(pressure_min),
		.pressure_max(pressure_max), .temp_min(temp_min), .temp_max(temp_max));
	bps_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	always #25 clk = ~clk;
	always @(posedge clk)
		if (buffer_pop === 1'b1)
			pops = pops + 1;
	task automatic end_of_test();
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input int n, input logic [63:0] ex);
		u_host.rd(a, n);
		for (int i = 0; i < n; i++)
			chk(nm, {24'h0000_00, ex[8 * (n - 1 - i) +: 8]}, {24'h0000_00, u_host.rb[i]});
	endtask
	task automatic sample(input logic [19:0] p, input logic [11:0] t);
		@(negedge clk);
		sample_pressure = p;
		sample_temp = t;
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{sample_valid, go_active, active_mode, buffer_overflow, buffer_watermark} = 5'h00;
		sample_pressure = 20'h0_0000;
		sample_temp = 12'h000;
		pressure_window = 16'h0018;
		temp_target = 8'hac;
		temp_window_value = 8'h00;
		buffer_flags = 8'h3c;
		buffer_byte = 8'h77;
		miscompares = 0;
		checks = 0;
		pops = 0;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("sea_level_ref", 32'h0000_c5e7, {16'h0000, sea_level_ref});
		rdchk("reset_map", 8'h0f, 8, 64'h0000_0000_00c5_e700);
		rdchk("id_and_port", 8'h0c, 4, 64'h5a3c_7777);
		chk("pops", 32'h0000_0002, pops);
		u_host.wr(8'h14, 16'haa55, 2);
		chk("sea_level_ref", 32'h0000_aa55, {16'h0000, sea_level_ref});
		u_host.wr(8'h0c, 16'h0000, 1);
		u_host.slow = 1'b1;
		rdchk("part_id", 8'h0c, 1, 64'h5a);
		u_host.slow = 1'b0;
		chk("naks", 32'h0000_0000, {24'h0000_00, u_host.naks});
		u_host.probe(8'hc2);
		chk("naks", 32'h0000_0001, {24'h0000_00, u_host.naks});
		sample(20'h1_2340, 12'hab0);
		sample(20'h1_2360, 12'hac0);
		chk("int_flags", 32'h0000_0081, {24'h0000_00, int_flags});
		chk("pressure_max", 32'h0001_2360, {12'h000, pressure_max});
		chk("temp_max", 32'h0000_0ac0, {20'h0_0000, temp_max});
		chk("pressure_min", 32'h0001_2340, {12'h000, pressure_min});
		chk("temp_min", 32'h0000_0ab0, {20'h0_0000, temp_min});
		rdchk("out_wrap", 8'h02, 6, 64'h3600_ac00_0012);
		rdchk("delta_wrap", 8'h0a, 5, 64'h01_0000_0002);
		rdchk("int_cause", 8'h12, 1, 64'h81);
		chk("int_flags", 32'h0000_0000, {24'h0000_00, int_flags});
		temp_window_value = 8'h01;
		sample(20'h1_2360, 12'hac0);
		chk("int_flags", 32'h0000_0088, {24'h0000_00, int_flags});
		pulse(buffer_watermark);
		chk("int_flags", 32'h0000_00c8, {24'h0000_00, int_flags});
		rdchk("int_cause", 8'h12, 1, 64'hc8);
		pulse(buffer_overflow);
		chk("int_flags", 32'h0000_00c0, {24'h0000_00, int_flags});
		u_host.wr(8'h0f, 16'h4000, 1);
		chk("buffer_mode", 32'h0000_0001, {30'h0000_0000, buffer_mode});
		pops = 0;
		rdchk("buffer_alias", 8'h00, 3, 64'h3c_7777);
		chk("pops", 32'h0000_0002, pops);
		u_host.wr(8'h0f, 16'h0000, 1);
		active_mode = 1'b1;
		pulse(go_active);
		rdchk("cleared_out", 8'h01, 4, 64'h0000_0000);
		rdchk("sysmode", 8'h11, 1, 64'h01);
		rdchk("kept_ref", 8'h14, 2, 64'haa55);
		u_host.wr(8'h13, 16'h5a00, 1);
		chk("event_config", 32'h0000_005a, {24'h0000_00, event_config});
		rdchk("part_id", 8'h0c, 1, 64'h5a);
		end_of_test();
	end
endmodule
